// >>> logic/sac_pkg.sv
// Package of constants and types for the scan front-end control registers
package sac_pkg;

   // Register byte addresses on the bus
   localparam logic [11:0] SAC_OFS_FE_CTL  = 12'h000;
   localparam logic [11:0] SAC_OFS_SEL_CTL = 12'h004;

   // Field positions in the front-end control word
   localparam int SAC_BIT_ALT   = 12;
   localparam int SAC_BIT_MVG   = 8;
   localparam int SAC_BIT_SH    = 7;
   localparam int SAC_BIT_EXC   = 6;
   localparam int SAC_BIT_CH1HI = 5;
   localparam int SAC_BIT_CH1LO = 4;
   localparam int SAC_BIT_CH0HI = 3;
   localparam int SAC_BIT_CH0LO = 2;
   localparam int SAC_BIT_RES1  = 1;
   localparam int SAC_BIT_RES0  = 0;

   // Read-only front-end output bits in the select control word
   localparam int SAC_SEL_RO_W = 4;

   // Values after reset
   localparam logic [15:0] SAC_RST_FE_CTL  = 16'h0000;
   localparam logic [15:0] SAC_RST_SEL_CTL = 16'h0000;

   // Input selection codes
   localparam logic [1:0] SAC_CODE_IN0 = 2'h0;
   localparam logic [1:0] SAC_CODE_IN1 = 2'h1;
   localparam logic [1:0] SAC_CODE_IN2 = 2'h2;
   localparam logic [1:0] SAC_CODE_IN3 = 2'h3;

   // AHB transfer type bit that marks an active transfer
   localparam int SAC_HTRANS_ACT = 1;

   // Pending data phase of the bus slave
   typedef enum logic [1:0] {
      SAC_PH_IDLE = 2'b00,
      SAC_PH_WFE  = 2'b01,
      SAC_PH_WSEL = 2'b10
   } sac_phase_t;

   // One-hot comparator input routing
   typedef struct packed {
      logic [3:0] alt_in;
      logic [2:0] sens_in;
   } sac_route_t;

   // All state of the register bank
   typedef struct packed {
      sac_phase_t  phase;
      logic [15:0] fe_ctl;
      logic [15:0] sel_ctl;
      logic [31:0] hrdata;
      logic        hreadyout;
      logic        mvg_on;
      logic        sh_on;
      logic        exc_on;
      sac_route_t  route;
   } sac_state_t;

endpackage

// >>> logic/sac_input_router.sv
// Comparator input router for one test-channel select code
`timescale 1ns/1ps
`default_nettype none

module sac_input_router
   import sac_pkg::*;
(
   input  wire logic [1:0] sel,
   input  wire logic       alt_route,
   output sac_route_t      route
);

   always_comb begin
      route = '0;
      case (sel)
         SAC_CODE_IN0: begin
            if (alt_route) route.alt_in[0] = 1'b1;
            else route.sens_in[0] = 1'b1;
         end
         SAC_CODE_IN1: begin
            if (alt_route) route.alt_in[1] = 1'b1;
            else route.sens_in[1] = 1'b1;
         end
         SAC_CODE_IN2: begin
            if (alt_route) route.alt_in[2] = 1'b1;
            else route.sens_in[2] = 1'b1;
         end
         SAC_CODE_IN3: begin
            route.alt_in[3] = 1'b1;
         end
         default: begin
            route = '0;
         end
      endcase
   end

endmodule

`default_nettype wire

// >>> logic/sac_regs.sv
// Scan front-end control and status registers behind an AHB-Lite slave
//
// Notes on behaviour
// - Mid-voltage generator is on only if enabled and sample-hold is 0.
// - Bit 7 set enables sample-and-hold; clear disables it.
// - Bit 6 set enables excitation circuitry; clear keeps it disabled.
// - Bits 5..4 pick the comparator input while test channel 1 is measured.
// - Bits 3..2 pick the comparator input while test channel 0 is measured.
// - Codes 0..2 pick sensor or alternate input by route bit; 3 picks alt 3.
// - Bit 1 holds test channel 1 result, bit 0 test channel 0 result.
//
// Our own choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module sac_regs
   import sac_pkg::*;
#(
   parameter int ADDR_W = 12
)
(
   input  wire logic              sys_clk,
   input  wire logic              rst_b,
   input  wire logic              clk_en,
   // AHB-Lite slave
   input  wire logic              hsel,
   input  wire logic [ADDR_W-1:0] haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic                   hresp,
   output logic [31:0]            hrdata,
   // Front end
   input  wire logic              meas_ch0,
   input  wire logic              meas_ch1,
   input  wire logic              comp_out,
   input  wire logic [3:0]        front_end_result,
   output logic                   mid_voltage_gen_on,
   output logic                   sample_hold_on,
   output logic                   excitation_on,
   output sac_route_t             comp_route
);

   // Refuse address widths that the decoder cannot serve
   if (ADDR_W < 3 || ADDR_W > 32) begin : g_bad_addr_w
      $error("ADDR_W must lie between 3 and 32");
   end

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   function automatic logic [31:0] sac_read(input logic [11:0] a,
                                            input sac_state_t  s);
      logic [31:0] d;
      d = 32'h0000_0000;
      if (a == SAC_OFS_FE_CTL) d[15:0] = s.fe_ctl;
      else if (a == SAC_OFS_SEL_CTL) d[15:0] = s.sel_ctl;
      return d;
   endfunction

   function automatic logic [11:0] sac_word_addr(input logic [ADDR_W-1:0] a);
      logic [31:0] w;
      w = 32'(a);
      // Any address above the map never matches a register
      if (w > 32'h0000_0fff) return 12'hffc;
      return {w[11:2], 2'b00};
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // State

   sac_state_t r;
   sac_state_t next_r;
   sac_route_t ch_route;
   logic [1:0] cur_sel;
   logic       addr_ok;
   logic [11:0] a_word;

   // Channel 1 select while it is measured, channel 0 otherwise
   assign cur_sel = meas_ch1 ? r.fe_ctl[SAC_BIT_CH1HI:SAC_BIT_CH1LO]
                             : r.fe_ctl[SAC_BIT_CH0HI:SAC_BIT_CH0LO];

   sac_input_router u_router (
      .sel       (cur_sel),
      .alt_route (r.fe_ctl[SAC_BIT_ALT]),
      .route     (ch_route)
   );

   assign addr_ok = hsel && htrans[SAC_HTRANS_ACT] && hready;
   assign a_word  = sac_word_addr(haddr);

   always_comb begin
      next_r = r;
      next_r.hreadyout = 1'b1;
      // Data phase of an earlier write
      case (r.phase)
         SAC_PH_WFE: begin
            next_r.fe_ctl = hwdata[15:0];
         end
         SAC_PH_WSEL: begin
            next_r.sel_ctl[15:SAC_SEL_RO_W] = hwdata[15:SAC_SEL_RO_W];
         end
         SAC_PH_IDLE: begin
            next_r.phase = SAC_PH_IDLE;
         end
         default: begin
            next_r.phase = SAC_PH_IDLE;
         end
      endcase
      // Hardware-owned bits win over a software write in the same cycle
      next_r.sel_ctl[SAC_SEL_RO_W-1:0] = front_end_result;
      if (meas_ch0) next_r.fe_ctl[SAC_BIT_RES0] = comp_out;
      if (meas_ch1) next_r.fe_ctl[SAC_BIT_RES1] = comp_out;
      // Address phase
      next_r.phase = SAC_PH_IDLE;
      if (addr_ok && hwrite) begin
         if (a_word == SAC_OFS_FE_CTL) next_r.phase = SAC_PH_WFE;
         else if (a_word == SAC_OFS_SEL_CTL) next_r.phase = SAC_PH_WSEL;
      end
      if (addr_ok && !hwrite) next_r.hrdata = sac_read(a_word, next_r);
      // Front-end controls follow the stored bits
      next_r.mvg_on = next_r.fe_ctl[SAC_BIT_MVG]
                      && !next_r.fe_ctl[SAC_BIT_SH];
      next_r.sh_on  = next_r.fe_ctl[SAC_BIT_SH];
      next_r.exc_on = next_r.fe_ctl[SAC_BIT_EXC];
      next_r.route  = ch_route;
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         r <= '{phase:     SAC_PH_IDLE,
                fe_ctl:    SAC_RST_FE_CTL,
                sel_ctl:   SAC_RST_SEL_CTL,
                hrdata:    32'h0000_0000,
                hreadyout: 1'b1,
                mvg_on:    1'b0,
                sh_on:     1'b0,
                exc_on:    1'b0,
                route:     '0};
      end else if (clk_en) begin
         r <= next_r;
      end
   end

   assign hreadyout          = r.hreadyout;
   assign hresp              = 1'b0;
   assign hrdata             = r.hrdata;
   assign mid_voltage_gen_on = r.mvg_on;
   assign sample_hold_on     = r.sh_on;
   assign excitation_on      = r.exc_on;
   assign comp_route         = r.route;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   a_mvg_gated: assert property (@(posedge sys_clk) disable iff (!rst_b)
      mid_voltage_gen_on == (r.fe_ctl[SAC_BIT_MVG] && !r.fe_ctl[SAC_BIT_SH]))
      else $error("mid-voltage generator not gated by sample-hold");

   a_sh_follows: assert property (@(posedge sys_clk)
      disable iff (!rst_b)
      sample_hold_on == r.fe_ctl[SAC_BIT_SH])
      else $error("sample-hold output differs from its bit");

   a_exc_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && r.phase == SAC_PH_WFE ##1 clk_en
      |=> excitation_on == $past(hwdata[SAC_BIT_EXC], 2))
      else $error("excitation output does not follow a write");

   a_ch1_route: assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && meas_ch1 && r.fe_ctl[SAC_BIT_CH1HI:SAC_BIT_CH1LO] == 2'h3
      |=> comp_route.alt_in[3] && comp_route.sens_in == 3'h0)
      else $error("channel 1 code 3 not routed to alternate 3");

   a_ch0_route: assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && !meas_ch1 && !r.fe_ctl[SAC_BIT_ALT]
      && r.fe_ctl[SAC_BIT_CH0HI:SAC_BIT_CH0LO] == 2'h0
      |=> comp_route == 7'h01)
      else $error("channel 0 code 0 not routed to sensor input 0");

   a_alt_route: assert property (@(posedge sys_clk)
      disable iff (!rst_b)
      clk_en && !meas_ch1 && r.fe_ctl[SAC_BIT_ALT]
      && r.fe_ctl[SAC_BIT_CH0HI:SAC_BIT_CH0LO] == SAC_CODE_IN1
      |=> comp_route == 7'h10)
      else $error("channel 0 code 1 not routed to alternate input 1");

   a_route_onehot: assert property (@(posedge sys_clk)
      disable iff (!rst_b)
      $past(clk_en) && $past(rst_b) |-> $onehot(comp_route))
      else $error("comparator routing not one-hot");

   a_result_latch: assert property (@(posedge sys_clk)
      disable iff (!rst_b)
      clk_en && meas_ch0 |=> r.fe_ctl[SAC_BIT_RES0] == $past(comp_out))
      else $error("channel 0 result not latched");

   a_res1_latch: assert property (@(posedge sys_clk)
      disable iff (!rst_b)
      clk_en && meas_ch1 |=> r.fe_ctl[SAC_BIT_RES1] == $past(comp_out))
      else $error("channel 1 result not latched");

   a_ro_bits: assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && r.phase == SAC_PH_WSEL
      |=> r.sel_ctl[3:0] == $past(front_end_result))
      else $error("read-only front-end bits taken from a write");

   a_read_data: assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && addr_ok && !hwrite && a_word == SAC_OFS_SEL_CTL
      && r.phase == SAC_PH_IDLE
      |=> hrdata[31:4] == {16'h0000, $past(r.sel_ctl[15:4])})
      else $error("select word read data wrong");

   a_fe_write: assert property (@(posedge sys_clk) disable iff (!rst_b)
      clk_en && r.phase == SAC_PH_WFE && !meas_ch0 && !meas_ch1
      |=> r.fe_ctl == $past(hwdata[15:0]))
      else $error("front-end word write did not land");

   a_bus_okay: assert property (@(posedge sys_clk) disable iff (!rst_b)
      hreadyout && !hresp)
      else $error("bus slave stalled or answered with an error");

endmodule

`default_nettype wire

// >>> testbench/scan_afe_control_regs_tb.sv
// Self-checking bench for the scan front-end control registers
`timescale 1ns/1ps
`default_nettype none

module scan_afe_control_regs_tb import sac_pkg::*;;

   logic        sys_clk;
   logic        rst_b;
   logic        clk_en;
   logic        hsel;
   logic [11:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic        meas_ch0;
   logic        meas_ch1;
   logic        comp_out;
   logic [3:0]  front_end_result;
   logic        mid_voltage_gen_on;
   logic        sample_hold_on;
   logic        excitation_on;
   sac_route_t  comp_route;
   sac_route_t  exp_route;
   int          n_mismatch;
   int          total_checks;

   sac_regs uut (
      .sys_clk            (sys_clk),
      .rst_b              (rst_b),
      .clk_en             (clk_en),
      .hsel               (hsel),
      .haddr              (haddr),
      .htrans             (htrans),
      .hwrite             (hwrite),
      .hsize              (hsize),
      .hwdata             (hwdata),
      .hready             (hreadyout),
      .hreadyout          (hreadyout),
      .hresp              (hresp),
      .hrdata             (hrdata),
      .meas_ch0           (meas_ch0),
      .meas_ch1           (meas_ch1),
      .comp_out           (comp_out),
      .front_end_result   (front_end_result),
      .mid_voltage_gen_on (mid_voltage_gen_on),
      .sample_hold_on     (sample_hold_on),
      .excitation_on      (excitation_on),
      .comp_route         (comp_route)
   );

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   // One single transfer: address phase, then data phase
   task automatic bus(input logic wr, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      @(posedge sys_clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'b10;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1) @(posedge sys_clk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge sys_clk);
      while (hreadyout !== 1'b1) @(posedge sys_clk);
      q = hrdata;
      check(32'(hresp), 32'h0);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      check(q, exp);
   endtask

   task automatic stop_test();
      $display("checks %0d, mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {rst_b, clk_en, hsel, haddr, htrans, hwrite} = '0;
      {hwdata, meas_ch0, meas_ch1, comp_out, front_end_result} = '0;
      hsize = 3'h2;
      n_mismatch = 0;
      total_checks = 0;
      repeat (8) @(posedge sys_clk);
      rst_b <= 1'b1;
      clk_en <= 1'b1;
      rd_chk(SAC_OFS_SEL_CTL, 32'h0);
      for (int i = 0; i < 8; i++) begin
         wr(SAC_OFS_FE_CTL, 32'(i) << SAC_BIT_EXC);
         @(posedge sys_clk);
         check(32'(mid_voltage_gen_on), 32'(i[2] & ~i[1]));
         check(32'(sample_hold_on), 32'(i[1]));
         check(32'(excitation_on), 32'(i[0]));
      end
      // Other channel holds the opposite code so a wrong pick shows
      for (int k = 0; k < 16; k++) begin
         meas_ch1 <= k[3];
         meas_ch0 <= ~k[3];
         wr(SAC_OFS_FE_CTL, (32'(k[2]) << SAC_BIT_ALT)
            | (32'(k[1:0]) << (k[3] ? SAC_BIT_CH1LO : SAC_BIT_CH0LO))
            | ({30'h0, ~k[1:0]} << (k[3] ? SAC_BIT_CH0LO : SAC_BIT_CH1LO)));
         repeat (2) @(posedge sys_clk);
         exp_route = '0;
         if (k[1:0] == 2'h3 || k[2]) exp_route.alt_in[k[1:0]] = 1'b1;
         else exp_route.sens_in[k[1:0]] = 1'b1;
         check(32'(comp_route), 32'(exp_route));
      end
      meas_ch1 <= 1'b0;
      meas_ch0 <= 1'b0;
      wr(SAC_OFS_FE_CTL, 32'h0);
      @(posedge sys_clk);
      meas_ch0 <= 1'b1;
      comp_out <= 1'b1;
      @(posedge sys_clk);
      meas_ch0 <= 1'b0;
      meas_ch1 <= 1'b1;
      @(posedge sys_clk);
      meas_ch1 <= 1'b0;
      comp_out <= 1'b0;
      rd_chk(SAC_OFS_FE_CTL, 32'h3);
      @(posedge sys_clk);
      meas_ch1 <= 1'b1;
      @(posedge sys_clk);
      meas_ch1 <= 1'b0;
      rd_chk(SAC_OFS_FE_CTL, 32'h1);
      // Frozen clock enable keeps a measurement from landing
      clk_en <= 1'b0;
      meas_ch0 <= 1'b1;
      repeat (3) @(posedge sys_clk);
      clk_en <= 1'b1;
      meas_ch0 <= 1'b0;
      rd_chk(SAC_OFS_FE_CTL, 32'h1);
      front_end_result <= 4'ha;
      wr(SAC_OFS_SEL_CTL, 32'hffff);
      rd_chk(SAC_OFS_SEL_CTL, 32'hfffa);
      front_end_result <= 4'h5;
      rd_chk(SAC_OFS_SEL_CTL, 32'hfff5);
      wr(12'h008, 32'hffff);
      rd_chk(12'h008, 32'h0);
      @(posedge sys_clk);
      rst_b <= 1'b0;
      front_end_result <= 4'h0;
      @(posedge sys_clk);
      rst_b <= 1'b1;
      rd_chk(SAC_OFS_SEL_CTL, 32'h0);
      stop_test();
   end

   initial begin
      repeat (3000) @(posedge sys_clk);
      n_mismatch++;
      stop_test();
   end

endmodule

`default_nettype wire
